// ### core/fill_pkg.sv
/*
  Shared types and constants for the weigh filling sequencer: recipe layout,
  configuration, plant pins and outputs, fault codes and sequencer states.
  Assumes one 20 MHz system clock; every delay is a count of its ticks.
*/
// What this block does
// [RULE_01] Keep nine recipe sets; run the selected one, keypad or remote chosen.
// [RULE_02] In idle, each reset/select pulse advances the recipe number by one.
// [RULE_03] A reset/select pulse during a cycle aborts and resets the filling.
// [RULE_04] Container start needs target plus max tare below capacity, tare and safety ok.
// [RULE_05] Container net filling tares the scale when start is accepted.
// [RULE_06] After the start delay raise valve down and hold it during filling.
// [RULE_07] Wait position delay for valve at bottom; else valve fault and error.
// [RULE_08] Bottom-up filling keeps valve low, then raises it until valve at middle.
// [RULE_09] Valve ready: coarse and fine feed on, weight ignored for coarse delay.
// [RULE_10] At target minus dribble drop coarse, ignore weight for fine delay.
// [RULE_11] At target minus preact drop fine feed, all feeding stops.
// [RULE_12] After feeding stops wait stability delay, then check tolerance band.
// [RULE_13] Underfill: fine feed for additional time, then check tolerance again.
// [RULE_14] Container end: release valve down; input must drop in position delay, else error.
// [RULE_15] Container end: raise end of filling, clear display, await new start; stat.shown keeps the net weight instead.
// [RULE_16] Container mode: feeding stops whenever the valve down input is passive.
// [RULE_17] Container mode: valve to bottom drops when the column lifting delay expires.
// [RULE_18] Hopper mode: optional start delay between start and filling sequence.
// [RULE_19] Hopper start: flap open after position delay gives error and gate fault.
// [RULE_20] Hopper zeroes scale; outside zero range shows zero fault, waits new start.
// [RULE_21] Hopper end: end of filling, actual weight shown, await discharge; band error.
// [RULE_22] Discharge: after delay open flap; flap closed must drop in position delay.
// [RULE_23] Monitored discharge: wait zero range, end delay, close flap, signal complete.
// [RULE_24] Delays count clock ticks from recipe; filling mode comes from configuration.
package fill_pkg;

  localparam int N_RECIPES = 9;
  localparam int W_W       = 20;
  localparam int T_W       = 24;
  localparam int RI_W      = 4;
  localparam int N_PINS    = 7;

  typedef logic [W_W-1:0]  weight_t;
  typedef logic [T_W-1:0]  ticks_t;
  typedef logic [RI_W-1:0] rcp_idx_t;

  localparam rcp_idx_t RCP_FIRST   = 4'h0;
  localparam rcp_idx_t RCP_LAST    = 4'h8;
  localparam rcp_idx_t RCP_STEP    = 4'h1;
  localparam ticks_t   TICK_ZERO   = 24'h000000;
  localparam ticks_t   TICK_ONE    = 24'h000001;
  localparam weight_t  WEIGHT_ZERO = 20'h00000;

  typedef enum logic {MODE_CONTAINER = 1'b0, MODE_HOPPER = 1'b1} fill_mode_t;

  typedef enum logic [2:0] {
    FAULT_NONE  = 3'h0,
    FAULT_VALVE = 3'h1,  // valve_fault_code
    FAULT_GATE  = 3'h2,
    FAULT_ZERO  = 3'h3,
    FAULT_TOL   = 3'h4
  } fault_t;

  // One recipe: weights in scale units, delays in clock ticks
  typedef struct packed {
    weight_t target;
    weight_t dribble;
    weight_t preact;
    weight_t tol_under;
    weight_t tol_over;
    weight_t zero_range;
    ticks_t  start_dly;
    ticks_t  pos_dly;
    ticks_t  coarse_dly;
    ticks_t  fine_dly;
    ticks_t  stab_dly;
    ticks_t  add_dly;
    ticks_t  lift_dly;
    ticks_t  dis_dly;
    ticks_t  dis_end_dly;
  } recipe_t;

  typedef struct packed {
    fill_mode_t mode;
    logic       net_fill;
    logic       bottom_fill;
    logic       start_dly_en;
    logic       dis_monitor;
    logic       add_feed_en;
    weight_t    max_cap;
    weight_t    safety;
    weight_t    max_tare;
  } cfg_t;

  typedef struct packed {
    logic start;
    logic discharge;
    logic reset_sel;
    logic valve_down;
    logic valve_bottom;
    logic valve_middle;
    logic flap_closed;
  } pins_t;

  typedef struct packed {
    logic coarse;
    logic fine;
    logic valve_down;
    logic valve_bottom;
    logic open_flap;
    logic eof;
    logic discharge_complete_out;
    logic error;
  } plant_t;

  typedef struct packed {
    fault_t   fault;
    rcp_idx_t recipe;
    logic     busy;
    logic     actual_weight_msg;
    weight_t  shown;
  } status_t;

  typedef enum logic [4:0] {
    S_IDLE      = 5'h00,
    S_START_DLY = 5'h01,
    S_VALVE_DN  = 5'h03,
    S_LIFT      = 5'h02,
    S_FEED      = 5'h06,
    S_COARSE    = 5'h07,
    S_FINE      = 5'h05,
    S_STAB      = 5'h04,
    S_ADD       = 5'h0C,
    S_VALVE_UP  = 5'h0D,
    S_FLAP      = 5'h0F,
    S_ZERO      = 5'h0E,
    S_ZERO_HOLD = 5'h0A,
    S_FULL      = 5'h0B,
    S_DIS_DLY   = 5'h09,
    S_FLAP_OPEN = 5'h08,
    S_EMPTY     = 5'h18,
    S_DIS_END   = 5'h19,
    S_FAULT     = 5'h1B
  } seq_state_t;

endpackage

// ### core/pin_sync.sv
/*
  Three-stage synchroniser for the plant pins with agreement filter.
  Assumes pins are asynchronous to core_clk_i; output moves only when
  the second and third stages agree.
*/
`timescale 1ns/100ps
module pin_sync
  import fill_pkg::*;
(
  // Clock, reset, enable
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // Pins in and filtered out
  input  wire pins_t pins_i,
  output pins_t      pins_o
);

  typedef struct packed {
    logic [N_PINS-1:0] s1;
    logic [N_PINS-1:0] s2;
    logic [N_PINS-1:0] s3;
    logic [N_PINS-1:0] q;
  } sync_state_t;

  sync_state_t sync_reg;
  sync_state_t sync_next;
  logic [N_PINS-1:0] agree;

  // First stage feeds only the second; the filter looks at stages two and three
  assign agree = ~(sync_reg.s2 ^ sync_reg.s3);

  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = pins_i;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    sync_next.q  = (sync_reg.q & ~agree) | (sync_reg.s3 & agree);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_reg <= '0;
    end else if (ce_i) begin
      sync_reg <= sync_next;
    end
  end

  assign pins_o = sync_reg.q;

endmodule

// ### core/weigh_filling_sequencer.sv
/*
  Filling sequencer: container filling and hopper fill-and-empty, recipe
  store and selection, plant output control.
  Assumes weight_i comes from logic on core_clk_i; plant pins are async.
*/
`timescale 1ns/100ps
module weigh_filling_sequencer
  import fill_pkg::*;
(
  // Clock, reset, enable
  input  wire logic     core_clk_i,
  input  wire logic     rst_n_i,
  input  wire logic     ce_i,
  // Weight and configuration
  input  wire weight_t  weight_i,
  input  wire cfg_t     cfg_i,
  // Recipe store and keypad selection
  input  wire logic     rcp_wr_i,
  input  wire rcp_idx_t rcp_wr_idx_i,
  input  wire recipe_t  rcp_wr_data_i,
  input  wire logic     key_sel_i,
  input  wire rcp_idx_t key_idx_i,
  // Plant pins
  input  wire pins_t    pins_i,
  output plant_t        plant_o,
  output status_t       status_o
);

  typedef struct packed {
    seq_state_t                  fsm;
    fill_mode_t                  mode;
    ticks_t                      tmr;
    weight_t                     tare;
    logic                        coarse_req;
    logic                        fine_req;
    pins_t                       pin_q;
    plant_t                      plant;
    status_t                     stat;
    recipe_t [N_RECIPES-1:0]     rcp;
  } seq_t;

  seq_t    seq_reg;
  seq_t    seq_next;
  pins_t   pin;
  pins_t   rise;
  recipe_t cur;
  weight_t net;
  logic    rs_rise;
  logic    under;
  logic    over;

  // Weight at or past target less an offset
  function automatic logic reached(weight_t w, weight_t tgt, weight_t off);
    reached = (w >= tgt - off);
  endfunction

  // Widened compare so base plus add cannot wrap
  function automatic logic exceeds(weight_t w, weight_t base, weight_t add);
    exceeds = ({1'b0, w} > ({1'b0, base} + {1'b0, add}));
  endfunction

  function automatic rcp_idx_t next_rcp(rcp_idx_t r);
    next_rcp = (r >= RCP_LAST) ? RCP_FIRST : r + RCP_STEP;
  endfunction

  function automatic ticks_t tick_down(ticks_t t);
    tick_down = (t == TICK_ZERO) ? TICK_ZERO : t - TICK_ONE;
  endfunction

  pin_sync u_pin_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .pins_i     (pins_i),
    .pins_o     (pin)
  );

  // Shared terms: edges, selected recipe, net weight, band results
  assign rise    = pin & ~seq_reg.pin_q;
  assign rs_rise = rise.reset_sel;
  assign cur     = seq_reg.rcp[seq_reg.stat.recipe];  // see [RULE_01]
  assign net     = weight_i - seq_reg.tare;
  assign under   = !reached(net, cur.target, cur.tol_under);
  assign over    = exceeds(net, cur.target, cur.tol_over);

  // Sequencer next state; every delay counts ticks loaded from the recipe
  always_comb begin
    seq_next       = seq_reg;
    seq_next.pin_q = pin;
    seq_next.tmr   = tick_down(seq_reg.tmr);  // see [RULE_24]
    if (rcp_wr_i && rcp_wr_idx_i <= RCP_LAST) begin
      seq_next.rcp[rcp_wr_idx_i] = rcp_wr_data_i;  // see [RULE_01]
    end
    if (rs_rise && seq_reg.fsm != S_IDLE) begin
      // Abort drops every actuator so the plant comes to rest
      seq_next.fsm                     = S_IDLE;  // see [RULE_03]
      seq_next.coarse_req              = 1'b0;
      seq_next.fine_req                = 1'b0;
      seq_next.plant                   = '0;
      seq_next.stat.fault              = FAULT_NONE;
      seq_next.stat.actual_weight_msg  = 1'b0;
    end else begin
      case (seq_reg.fsm)
        S_IDLE: begin
          if (rs_rise) begin
            seq_next.stat.recipe = next_rcp(seq_reg.stat.recipe);  // see [RULE_02]
          end else if (key_sel_i && key_idx_i <= RCP_LAST) begin
            seq_next.stat.recipe = key_idx_i;  // see [RULE_01]
          end else if (rise.start) begin
            seq_next.mode = cfg_i.mode;  // see [RULE_24]
            if (cfg_i.mode == MODE_CONTAINER) begin
              // Start is refused silently unless the initial checks hold
              if (exceeds(cfg_i.max_cap, cur.target, cfg_i.max_tare) &&
                  weight_i <= cfg_i.max_tare && weight_i <= cfg_i.safety) begin  // see [RULE_04]
                seq_next.tare  = cfg_i.net_fill ? weight_i : WEIGHT_ZERO;  // see [RULE_05]
                seq_next.fsm   = S_START_DLY;
                seq_next.tmr   = cur.start_dly;
                seq_next.plant = '0;
                seq_next.stat.fault = FAULT_NONE;
                seq_next.stat.actual_weight_msg = 1'b0;
              end
            end else if (cfg_i.max_cap > cur.target) begin
              seq_next.fsm   = cfg_i.start_dly_en ? S_START_DLY : S_FLAP;  // see [RULE_18]
              seq_next.tmr   = cfg_i.start_dly_en ? cur.start_dly : cur.pos_dly;
              seq_next.plant = '0;
              seq_next.stat.fault = FAULT_NONE;
              seq_next.stat.actual_weight_msg = 1'b0;
            end
          end
        end
        S_START_DLY: begin
          if (seq_reg.tmr == TICK_ZERO) begin
            seq_next.tmr = cur.pos_dly;
            if (seq_reg.mode == MODE_CONTAINER) begin
              seq_next.fsm                = S_VALVE_DN;
              seq_next.plant.valve_down   = 1'b1;  // see [RULE_06]
              seq_next.plant.valve_bottom = cfg_i.bottom_fill;  // see [RULE_08]
            end else begin
              seq_next.fsm = S_FLAP;
            end
          end
        end
        S_VALVE_DN: begin
          // Timeout flags the fault but filling still waits for the input
          if (pin.valve_bottom) begin
            seq_next.fsm = cfg_i.bottom_fill ? S_LIFT : S_FEED;  // see [RULE_07]
            seq_next.tmr = cur.lift_dly;
          end else if (seq_reg.tmr == TICK_ZERO) begin
            seq_next.plant.error = 1'b1;  // see [RULE_07]
            seq_next.stat.fault  = FAULT_VALVE;
          end
        end
        S_LIFT: begin
          if (seq_reg.tmr == TICK_ZERO) begin
            seq_next.plant.valve_bottom = 1'b0;  // see [RULE_17]
            if (pin.valve_middle) begin
              seq_next.fsm = S_FEED;  // see [RULE_08]
            end
          end
        end
        S_FEED: begin
          seq_next.coarse_req = 1'b1;  // see [RULE_09]
          seq_next.fine_req   = 1'b1;
          seq_next.tmr        = cur.coarse_dly;
          seq_next.fsm        = S_COARSE;
        end
        S_COARSE: begin
          if (seq_reg.tmr == TICK_ZERO && reached(net, cur.target, cur.dribble)) begin
            seq_next.coarse_req = 1'b0;  // see [RULE_10]
            seq_next.tmr        = cur.fine_dly;
            seq_next.fsm        = S_FINE;
          end
        end
        S_FINE: begin
          if (seq_reg.tmr == TICK_ZERO && reached(net, cur.target, cur.preact)) begin
            seq_next.fine_req = 1'b0;  // see [RULE_11]
            seq_next.tmr      = cur.stab_dly;  // see [RULE_12]
            seq_next.fsm      = S_STAB;
          end
        end
        S_STAB: begin
          if (seq_reg.tmr == TICK_ZERO) begin
            seq_next.stat.shown = net;
            if (under && cfg_i.add_feed_en) begin
              seq_next.fine_req = 1'b1;  // see [RULE_13]
              seq_next.tmr      = cur.add_dly;
              seq_next.fsm      = S_ADD;
            end else begin
              if (under || over) begin
                seq_next.plant.error = 1'b1;  // see [RULE_21]
                seq_next.stat.fault  = FAULT_TOL;
              end
              if (seq_reg.mode == MODE_CONTAINER) begin
                seq_next.plant.valve_down   = 1'b0;  // see [RULE_14]
                seq_next.plant.valve_bottom = 1'b0;
                seq_next.tmr                = cur.pos_dly;
                seq_next.fsm                = S_VALVE_UP;
              end else begin
                seq_next.plant.eof              = 1'b1;  // see [RULE_21]
                seq_next.stat.actual_weight_msg = 1'b1;
                seq_next.fsm                    = S_FULL;
              end
            end
          end
        end
        S_ADD: begin
          if (seq_reg.tmr == TICK_ZERO) begin
            seq_next.fine_req = 1'b0;  // see [RULE_13]
            seq_next.tmr      = cur.stab_dly;
            seq_next.fsm      = S_STAB;
          end
        end
        S_VALVE_UP: begin
          if (!pin.valve_down) begin
            seq_next.plant.eof = 1'b1;  // see [RULE_15]
            seq_next.fsm       = S_IDLE;
          end else if (seq_reg.tmr == TICK_ZERO) begin
            seq_next.plant.error = 1'b1;  // see [RULE_14]
          end
        end
        S_FLAP: begin
          if (pin.flap_closed) begin
            seq_next.fsm = S_ZERO;
          end else if (seq_reg.tmr == TICK_ZERO) begin
            seq_next.plant.error = 1'b1;  // see [RULE_19]
            seq_next.stat.fault  = FAULT_GATE;
            seq_next.fsm         = S_FAULT;
          end
        end
        S_ZERO: begin
          if (weight_i <= cur.zero_range) begin
            seq_next.tare = weight_i;  // see [RULE_20]
            seq_next.fsm  = S_FEED;
          end else begin
            seq_next.stat.fault = FAULT_ZERO;  // see [RULE_20]
            seq_next.fsm        = S_ZERO_HOLD;
          end
        end
        S_ZERO_HOLD: begin
          if (rise.start && weight_i <= cur.zero_range) begin
            seq_next.stat.fault = FAULT_NONE;  // see [RULE_20]
            seq_next.tare       = weight_i;
            seq_next.fsm        = S_FEED;
          end
        end
        S_FULL: begin
          if (rise.discharge) begin
            seq_next.plant.eof = 1'b0;
            seq_next.tmr       = cur.dis_dly;  // see [RULE_22]
            seq_next.fsm       = S_DIS_DLY;
          end
        end
        S_DIS_DLY: begin
          if (seq_reg.tmr == TICK_ZERO) begin
            seq_next.plant.open_flap = 1'b1;  // see [RULE_22]
            seq_next.tmr             = cur.pos_dly;
            seq_next.fsm             = S_FLAP_OPEN;
          end
        end
        S_FLAP_OPEN: begin
          if (!pin.flap_closed) begin
            seq_next.fsm = cfg_i.dis_monitor ? S_EMPTY : S_DIS_END;
            seq_next.tmr = cur.dis_end_dly;
          end else if (seq_reg.tmr == TICK_ZERO) begin
            seq_next.plant.error = 1'b1;  // see [RULE_22]
            seq_next.stat.fault  = FAULT_GATE;
            seq_next.fsm         = S_FAULT;
          end
        end
        S_EMPTY: begin
          // Gross weight is watched; the hopper tare is its own empty weight
          if (weight_i <= cur.zero_range) begin
            seq_next.tmr = cur.dis_end_dly;  // see [RULE_23]
            seq_next.fsm = S_DIS_END;
          end
        end
        S_DIS_END: begin
          if (seq_reg.tmr == TICK_ZERO) begin
            seq_next.plant.open_flap              = 1'b0;  // see [RULE_23]
            seq_next.plant.discharge_complete_out = 1'b1;
            seq_next.stat.actual_weight_msg       = 1'b0;
            seq_next.fsm                          = S_IDLE;
          end
        end
        S_FAULT: begin
          seq_next.fsm = S_FAULT;
        end
        default: begin
          seq_next.fsm = S_IDLE;
        end
      endcase
    end
    // Feeding follows the requests, cut at once while the valve is out
    seq_next.plant.coarse = seq_next.coarse_req;
    seq_next.plant.fine   = seq_next.fine_req;
    if (seq_next.mode == MODE_CONTAINER && !pin.valve_down) begin
      seq_next.plant.coarse = 1'b0;  // see [RULE_16]
      seq_next.plant.fine   = 1'b0;
    end
    seq_next.stat.busy = (seq_next.fsm != S_IDLE);
  end

  // State register; the enable freezes everything including the recipes
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq_reg <= '0;
    end else if (ce_i) begin
      seq_reg <= seq_next;
    end
  end

  assign plant_o  = seq_reg.plant;
  assign status_o = seq_reg.stat;

  // Checks on the sequencer
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  coarse_with_fine_a: assert property (seq_reg.plant.coarse |-> seq_reg.plant.fine) // see [RULE_10]
    else $error("coarse feed without fine feed");
  feed_gate_a: assert property (ce_i && seq_reg.mode == MODE_CONTAINER && !pin.valve_down // see [RULE_16]
      |=> !seq_reg.plant.coarse && !seq_reg.plant.fine)
    else $error("feed active with valve not down");
  abort_cycle_a: assert property (ce_i && rs_rise && seq_reg.fsm != S_IDLE // see [RULE_03]
      |=> seq_reg.fsm == S_IDLE && seq_reg.plant == '0)
    else $error("reset input did not abort the cycle");
  recipe_step_a: assert property (ce_i && rs_rise && seq_reg.fsm == S_IDLE // see [RULE_02]
      |=> seq_reg.stat.recipe == next_rcp($past(seq_reg.stat.recipe)))
    else $error("recipe did not advance by one");
  recipe_range_a: assert property (seq_reg.stat.recipe <= RCP_LAST) // see [RULE_01]
    else $error("recipe number out of range");
  valve_held_a: assert property (seq_reg.mode == MODE_CONTAINER && // see [RULE_06]
      (seq_reg.fsm inside {S_FEED, S_COARSE, S_FINE, S_STAB, S_ADD}) |-> seq_reg.plant.valve_down)
    else $error("valve down released during filling");
  start_refused_a: assert property (ce_i && seq_reg.fsm == S_IDLE && rise.start && // see [RULE_04]
      !rs_rise && !key_sel_i && cfg_i.mode == MODE_CONTAINER && weight_i > cfg_i.safety
      |=> seq_reg.fsm == S_IDLE)
    else $error("start accepted above safety limit");
  fault_error_a: assert property (seq_reg.fsm == S_FAULT |-> seq_reg.plant.error && // see [RULE_19]
      seq_reg.stat.fault == FAULT_GATE)
    else $error("gate fault without error output");
  flap_closed_end_a: assert property (ce_i && seq_reg.fsm == S_DIS_END && // see [RULE_23]
      seq_reg.tmr == TICK_ZERO && !rs_rise
      |=> seq_reg.plant.discharge_complete_out && !seq_reg.plant.open_flap)
    else $error("discharge end without closing flap");

  fill_done_c: cover property (seq_reg.plant.eof && seq_reg.mode == MODE_CONTAINER);
  add_feed_c: cover property (seq_reg.fsm == S_ADD);
  discharge_c: cover property (seq_reg.plant.discharge_complete_out);

endmodule

// ### tb/plant_model.sv
/*
  Plant model: valve column, position switches, flap and a scale.
  Assumes plant_i comes from the sequencer on the same clock.
*/
`timescale 1ns/100ps
module plant_model
  import fill_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // Sequencer outputs in, plant answers out
  input  wire plant_t plant_i,
  output weight_t     weight_o,
  output logic        valve_down_o,
  output logic        valve_bottom_o,
  output logic        flap_closed_o
);
  // Valve travels one cycle per stage, so the switches lag the command
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      weight_o       <= WEIGHT_ZERO;
      valve_down_o   <= 1'b0;
      valve_bottom_o <= 1'b0;
      flap_closed_o  <= 1'b1;
    end else begin
      valve_down_o   <= plant_i.valve_down;
      valve_bottom_o <= valve_down_o;
      flap_closed_o  <= !plant_i.open_flap;
      // Removing the container empties the scale for the next start
      if (plant_i.eof)
        weight_o <= WEIGHT_ZERO;
      else if (plant_i.coarse)
        weight_o <= weight_o + 20'h00002;
      else if (plant_i.fine)
        weight_o <= weight_o + 20'h00001;
    end
  end
endmodule

// ### tb/tb.sv
/*
  Self-checking bench for the filling sequencer in container and hopper modes.
  Assumes plant_model stands in for the valves and scale.
*/
`timescale 1ns/100ps
module tb;
  import fill_pkg::*;
  logic    core_clk_i = 1'b0;
  logic    rst_n_i    = 1'b0;
  logic    rcp_wr_i   = 1'b0;
  logic    start_pin  = 1'b0;
  logic    sel_pin    = 1'b0;
  logic    dis_pin    = 1'b0;
  logic    key_sel    = 1'b0;
  rcp_idx_t key_idx   = 4'h0;
  cfg_t    cfg        = '{MODE_CONTAINER, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1,
                          20'h01000, 20'h00100, 20'h00010};
  recipe_t rcp        = '{20'h000C8, 20'h00028, 20'h00004, 20'h0000A, 20'h0000A,
                          20'h00005, 24'h000003, 24'h000014, 24'h000004, 24'h000004,
                          24'h000004, 24'h000004, 24'h000004, 24'h000003, 24'h000003};
  weight_t weight;
  logic    v_down, v_bot, f_closed;
  pins_t   pins;
  plant_t  plant_o;
  status_t status_o;
  int      err_total = 0;
  int      cmp_count = 0;

  // Pins: start, discharge, select, valve down, bottom, middle, flap closed
  // Middle switch follows the bottom switch, so a lift ends once its delay is over
  assign pins = '{start_pin, dis_pin, sel_pin, v_down, v_bot, v_bot, f_closed};

  always #25 core_clk_i = ~core_clk_i;

  weigh_filling_sequencer u_weigh_filling_sequencer (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .weight_i(weight),
    .cfg_i(cfg), .rcp_wr_i(rcp_wr_i), .rcp_wr_idx_i(4'h0), .rcp_wr_data_i(rcp),
    .key_sel_i(key_sel), .key_idx_i(key_idx), .pins_i(pins), .plant_o(plant_o),
    .status_o(status_o));

  plant_model u_plant_model (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .plant_i(plant_o), .weight_o(weight),
    .valve_down_o(v_down), .valve_bottom_o(v_bot), .flap_closed_o(f_closed));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Long enough high and low to pass three flip-flops and the agreement check
  // Pin choice: 0 start, 1 reset/select, 2 discharge
  task automatic pulse(input int which);
    @(posedge core_clk_i);
    case (which)
      1: sel_pin <= 1'b1;
      2: dis_pin <= 1'b1;
      default: start_pin <= 1'b1;
    endcase
    repeat (8) @(posedge core_clk_i);
    start_pin <= 1'b0;
    sel_pin   <= 1'b0;
    dis_pin   <= 1'b0;
    repeat (8) @(posedge core_clk_i);
  endtask

  // Bounded wait for one plant output bit; overrun ends the run
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    while (plant_o[b] !== 1'b1 && n < 3000) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n == 3000) begin
      err_total++;
      report_and_stop();
    end
  endtask

  // Keypad picks a recipe; select pulses step it and wrap after the ninth
  task automatic sc_select();
    check(status_o.recipe, 32'h0);
    key_idx <= RCP_LAST;
    key_sel <= 1'b1;
    @(posedge core_clk_i);
    key_sel <= 1'b0;
    @(posedge core_clk_i);
    check(status_o.recipe, 32'h8);
    pulse(1'b1);
    check(status_o.recipe, 32'h0);
    repeat (3) pulse(1'b1);
    check(status_o.recipe, 32'h3);
    repeat (6) pulse(1'b1);
    check(status_o.recipe, 32'h0);
  endtask

  // Target plus maximum tare not below capacity: start is ignored
  task automatic sc_refuse();
    @(posedge core_clk_i);
    cfg.max_cap <= 20'h000D0;
    pulse(1'b0);
    check(status_o.busy, 32'h0);
    cfg.max_cap <= 20'h01000;
  endtask

  // Full container cycle ends with feeds off, valve up and end of filling
  task automatic sc_fill();
    pulse(1'b0);
    check(status_o.busy, 32'h1);
    wait_bit(7);
    check(plant_o.fine, 32'h1);
    check(plant_o.valve_down, 32'h1);
    wait_bit(2);
    check(plant_o.coarse | plant_o.fine, 32'h0);
    check(plant_o.valve_down, 32'h0);
    check(plant_o.error, 32'h0);
    check(status_o.fault, 32'h0);
    check(status_o.shown >= 20'h000BE && status_o.shown <= 20'h000D2, 32'h1);
  endtask

  // Hopper cycle: start delay, zeroing, fill, hold full, then discharge through the flap
  task automatic sc_hopper();
    cfg.mode         <= MODE_HOPPER;
    cfg.start_dly_en <= 1'b1;
    cfg.dis_monitor  <= 1'b1;
    pulse(1'b0);
    check(status_o.busy, 32'h1);
    wait_bit(2);
    check(status_o.actual_weight_msg, 32'h1);
    check(plant_o.error, 32'h0);
    check(status_o.fault, 32'h0);
    check(status_o.shown >= 20'h000BE && status_o.shown <= 20'h000D2, 32'h1);
    pulse(2);
    check(plant_o.open_flap, 32'h1);
    check(plant_o.eof, 32'h0);
    wait_bit(1);
    check(plant_o.open_flap, 32'h0);
    check(status_o.busy, 32'h0);
    cfg.mode <= MODE_CONTAINER;
  endtask

  // Bottom-up fill lifts the valve before feeding; a select pulse then aborts
  task automatic sc_abort();
    cfg.bottom_fill <= 1'b1;
    pulse(1'b0);
    wait_bit(7);
    check(plant_o.valve_bottom, 32'h0);
    pulse(1'b1);
    check(status_o.busy, 32'h0);
    check(plant_o, 32'h0);
  endtask

  // Material left by the abort keeps a hopper start in the zero hold
  task automatic sc_zero();
    cfg.mode <= MODE_HOPPER;
    pulse(1'b0);
    check(status_o.fault, 32'h3);
    check(status_o.busy, 32'h1);
  endtask

  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rcp_wr_i <= 1'b1;
    @(posedge core_clk_i);
    rcp_wr_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    sc_select();
    sc_refuse();
    sc_fill();
    sc_hopper();
    sc_abort();
    sc_zero();
    report_and_stop();
  end
endmodule
